// File: hdl/cou_pkg.sv
// Shared constants and types for the charger option control block.
// Assumes one 200 MHz clock; timing kept in 1 ms ticks from a divider.
`default_nettype none
package cou_pkg;

    // Clock and tick divider
    localparam int CLK_MHZ = 200;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_MHZ * TICK_US;

    // Times in milliseconds, counted in 1 ms ticks
    localparam logic [17:0] DGL_SHORT_MS = 18'd150;
    localparam logic [17:0] DGL_LONG_MS = 18'd1300;
    localparam logic [17:0] WDT_44_MS = 18'd44000;
    localparam logic [17:0] WDT_88_MS = 18'd88000;
    localparam logic [17:0] WDT_175_MS = 18'd175000;

    // Depletion comparator
    localparam logic [16:0] HYST_MV = 17'd340;
    localparam logic [13:0] DEP_FRAC_00 = 14'd5919;
    localparam logic [13:0] DEP_FRAC_01 = 14'd6265;
    localparam logic [13:0] DEP_FRAC_10 = 14'd6655;
    localparam logic [13:0] DEP_FRAC_11 = 14'd7097;
    localparam logic [29:0] FRAC_SCALE = 30'd10000;

    // SMBus slave address and command codes
    localparam logic [6:0] SMB_ADDR = 7'h09;
    localparam logic [7:0] CMD_OPTION = 8'h12;
    localparam logic [7:0] CMD_CHG_CUR = 8'h14;
    localparam logic [7:0] CMD_CHG_VOLT = 8'h15;
    localparam logic [7:0] CMD_MFR_ID = 8'hFE;
    localparam logic [7:0] CMD_DEV_ID = 8'hFF;

    // Reset values
    localparam logic [15:0] OPTION_RST = 16'hF902;
    localparam logic [15:0] SETTING_RST = 16'h0000;

    // Lower byte field positions and read-only mask
    localparam int LEARN_BIT = 6;
    localparam int ADP_IND_BIT = 4;
    localparam int BOOST_EN_BIT = 3;
    localparam int BOOST_IND_BIT = 2;
    localparam int INHIBIT_BIT = 0;
    localparam logic [7:0] LOW_RO_MASK = 8'h14;

    // Watchdog select codes
    localparam logic [1:0] WDT_OFF = 2'b00;
    localparam logic [1:0] WDT_SEL_44 = 2'b01;
    localparam logic [1:0] WDT_SEL_88 = 2'b10;

    // Option word, bit 15 first
    typedef struct packed {
        logic dgl_long;
        logic [1:0] wdt_sel;
        logic [1:0] dep_sel;
        logic freq_up;
        logic freq_en;
        logic hs_fault_en;
        logic [7:0] low;
    } cou_opt_t;

    typedef enum {
        PH_IDLE, PH_ADDR, PH_CMD, PH_WLO, PH_WHI, PH_RLO, PH_RHI, PH_SKIP
    } cou_phase_t;

endpackage : cou_pkg
`default_nettype wire

// File: hdl/cou_charger_option.sv
// Charger option control: SMBus word slave, option register upper byte,
// adapter-good deglitch, charge watchdog and battery depletion logic.
// Assumes SMBus pins and comparator levels are asynchronous; battery
// voltage arrives in mV from a converter on the same clock.
`default_nettype none
module cou_charger_option import cou_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC,       // Cycles per 1 ms tick
    parameter logic [6:0] SLAVE_ADDR = SMB_ADDR,
    parameter logic [15:0] MFR_ID = 16'h00A5,   // Arbitrary value
    parameter logic [15:0] DEV_ID = 16'h005A    // Arbitrary value
) (
    input wire logic clk_i,                     // 200 MHz clock
    input wire logic rstn_i,                    // Sync reset, active low
    input wire logic smb_scl_i,                 // SMBus clock pin
    input wire logic smb_sda_i,                 // SMBus data pin level
    output logic smb_sda_o,                     // SMBus data out, always 0
    output logic smb_sda_oe_o,                  // High pulls data low
    input wire logic vcc_above_uvlo_i,          // Supply above lockout
    input wire logic adapter_detect_input_i,    // Detect pin above 0.6 V
    input wire logic adapter_present_i,         // Adapter present comparator
    input wire logic boost_request_i,           // System asks for boost
    input wire logic [15:0] battery_mv_i,       // Battery voltage, mV
    output logic adapter_good_indication_o,     // Deglitched adapter good
    output logic adapter_switch_transistor_o,   // Adapter switch on
    output logic battery_switch_transistor_o,   // Battery switch on
    output logic charge_enable_o,               // Charging allowed
    output logic boost_run_o,                   // Boost running
    output logic freq_adjust_en_o,              // Frequency shift enable
    output logic freq_raise_o,                  // Shift up, else down
    output logic high_side_fault_threshold_o,   // 750 mV detect enabled
    output logic depletion_o,                   // Battery depleted
    output logic wdt_suspended_o                // Watchdog has suspended
);

    // Falling threshold as a fraction of the regulation limit
    function automatic logic [16:0] fall_mv(input logic [15:0] vreg,
                                            input logic [1:0] sel);
        logic [13:0] frac;
        logic [29:0] prod;
        frac = DEP_FRAC_11;
        unique case (sel)
            2'b00: frac = DEP_FRAC_00;
            2'b01: frac = DEP_FRAC_01;
            2'b10: frac = DEP_FRAC_10;
            2'b11: frac = DEP_FRAC_11;
        endcase
        prod = 30'(vreg) * 30'(frac);
        return 17'(prod / FRAC_SCALE);
    endfunction : fall_mv

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic scl_s, sda_s, smb_en, adp_s, boost_req_s;

    // Two flops per pin; bus lines idle high
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_q <= 6'h03;
            sync_q <= 6'h03;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            meta_q <= {boost_request_i, adapter_present_i,
                       adapter_detect_input_i, vcc_above_uvlo_i,
                       smb_sda_i, smb_scl_i};
            sync_q <= meta_q;
            scl_prev_q <= sync_q[0];
            sda_prev_q <= sync_q[1];
        end
    end

    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];
    assign smb_en = sync_q[2] & sync_q[3];
    assign adp_s = sync_q[4];
    assign boost_req_s = sync_q[5];

    ////////////////////////////////////////////////////////////////////////
    // SMBus word slave
    logic bus_start, bus_stop, scl_rise, scl_fall;
    cou_phase_t phase_q;
    logic [2:0] bit_cnt_q;
    logic ack_q, ack_me_q, rd_q, wr_stb_q;
    logic [7:0] shift_q, cmd_q, wlo_q, whi_q, tx_q;
    logic [7:0] rx_byte;
    logic [15:0] rd_word;
    cou_opt_t wr_word;
    cou_opt_t opt_q;
    logic [15:0] cv_q, cc_q;
    logic good_q, boost_q;

    // Conditions on the synchronised bus lines
    assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign scl_rise = scl_s & ~scl_prev_q;
    assign scl_fall = ~scl_s & scl_prev_q;
    assign rx_byte = {shift_q[6:0], sda_s};
    assign wr_word = cou_opt_t'({whi_q, wlo_q});

    // Read data; status bits are live, not stored
    always_comb begin
        rd_word = 16'h0000;
        unique case (cmd_q)
            CMD_OPTION: begin
                rd_word = opt_q;
                rd_word[ADP_IND_BIT] = adp_s;
                rd_word[BOOST_IND_BIT] = boost_q;
            end
            CMD_CHG_CUR: rd_word = cc_q;
            CMD_CHG_VOLT: rd_word = cv_q;
            CMD_MFR_ID: rd_word = MFR_ID;
            CMD_DEV_ID: rd_word = DEV_ID;
            default: rd_word = 16'h0000;
        endcase
    end

    // Byte sequencing on clock rising edges; low byte travels first
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            phase_q <= PH_IDLE;
            bit_cnt_q <= 3'h0;
            ack_q <= 1'b0;
            ack_me_q <= 1'b0;
            rd_q <= 1'b0;
            wr_stb_q <= 1'b0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            wlo_q <= 8'h00;
            whi_q <= 8'h00;
            tx_q <= 8'h00;
        end else begin
            wr_stb_q <= 1'b0;
            if (bus_start) begin
                phase_q <= PH_ADDR;
                bit_cnt_q <= 3'h0;
                ack_q <= 1'b0;
            end else if (bus_stop) begin
                phase_q <= PH_IDLE;
                ack_q <= 1'b0;
            end else if (scl_rise && phase_q != PH_IDLE
                         && phase_q != PH_SKIP) begin
                if (ack_q) begin
                    ack_q <= 1'b0;
                    bit_cnt_q <= 3'h0;
                    case (phase_q)
                        PH_ADDR: phase_q <= rd_q ? PH_RLO : PH_CMD;
                        PH_CMD: phase_q <= PH_WLO;
                        PH_WLO: phase_q <= PH_WHI;
                        PH_RLO: begin
                            // Host not-acknowledge ends the read early
                            phase_q <= sda_s ? PH_SKIP : PH_RHI;
                            tx_q <= rd_word[15:8];
                        end
                        default: phase_q <= PH_SKIP;
                    endcase
                end else begin
                    shift_q <= rx_byte;
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                    if (bit_cnt_q == 3'h7) begin
                        ack_q <= 1'b1;
                        ack_me_q <= 1'b1;
                        case (phase_q)
                            PH_ADDR: begin
                                // Locked-out device stays off the bus
                                if (rx_byte[7:1] == SLAVE_ADDR
                                    && smb_en) begin
                                    rd_q <= rx_byte[0];
                                    tx_q <= rd_word[7:0];
                                end else begin
                                    ack_q <= 1'b0;
                                    phase_q <= PH_SKIP;
                                end
                            end
                            PH_CMD: cmd_q <= rx_byte;
                            PH_WLO: wlo_q <= rx_byte;
                            PH_WHI: begin
                                whi_q <= rx_byte;
                                wr_stb_q <= 1'b1;
                            end
                            default: ack_me_q <= 1'b0;
                        endcase
                    end
                end
            end
        end
    end

    // Data line changes only while the clock is low
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            smb_sda_oe_o <= 1'b0;
        end else if (bus_start || bus_stop) begin
            smb_sda_oe_o <= 1'b0;
        end else if (scl_fall) begin
            if (ack_q) begin
                smb_sda_oe_o <= ack_me_q;
            end else if (phase_q == PH_RLO || phase_q == PH_RHI) begin
                smb_sda_oe_o <= ~tx_q[3'h7 - bit_cnt_q];
            end else begin
                smb_sda_oe_o <= 1'b0;
            end
        end
    end

    assign smb_sda_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic learn_active, learn_clr, dep_q;

    // Option word; a host write wins over the automatic learn clear
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            opt_q <= OPTION_RST;
        end else if (wr_stb_q && cmd_q == CMD_OPTION) begin
            opt_q <= cou_opt_t'({whi_q, wlo_q & ~LOW_RO_MASK});
        end else if (learn_clr) begin
            opt_q.low[LEARN_BIT] <= 1'b0;
        end
    end

    // Charge voltage and current settings
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cv_q <= SETTING_RST;
            cc_q <= SETTING_RST;
        end else if (wr_stb_q) begin
            if (cmd_q == CMD_CHG_VOLT) cv_q <= {whi_q, wlo_q};
            if (cmd_q == CMD_CHG_CUR) cc_q <= {whi_q, wlo_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick
    logic [31:0] tick_cnt_q;
    logic tick;

    assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (!rstn_i || tick) tick_cnt_q <= 32'h0;
        else tick_cnt_q <= tick_cnt_q + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Adapter-good rising-edge deglitch
    logic [17:0] dgl_cnt_q, dgl_lim;
    logic ac_off_seen_q, ac_sw_q, bat_sw_q;

    // Long option only once the adapter switch has opened
    assign dgl_lim = (ac_off_seen_q && opt_q.dgl_long) ?
                     DGL_LONG_MS : DGL_SHORT_MS;

    // Falling edge of adapter presence clears good at once
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !adp_s) begin
            dgl_cnt_q <= 18'h0;
            good_q <= 1'b0;
        end else if (!good_q && tick) begin
            if (dgl_cnt_q + 18'h1 >= dgl_lim) good_q <= 1'b1;
            else dgl_cnt_q <= dgl_cnt_q + 18'h1;
        end
    end

    // Remember the first opening of the adapter switch
    always_ff @(posedge clk_i) begin
        if (!rstn_i) ac_off_seen_q <= 1'b0;
        else if (ac_sw_q && !(good_q && !learn_active))
            ac_off_seen_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Depletion comparator, learn cycle and boost
    logic prot_en;
    logic [16:0] fall_th, rise_th;

    assign prot_en = (cv_q != 16'h0000);
    assign fall_th = fall_mv(cv_q, opt_q.dep_sel);
    assign rise_th = fall_th + HYST_MV;
    assign learn_active = opt_q.low[LEARN_BIT] & good_q;
    assign learn_clr = learn_active & dep_q;

    // Hysteretic depleted flag
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !prot_en) dep_q <= 1'b0;
        else if (17'(battery_mv_i) < fall_th) dep_q <= 1'b1;
        else if (17'(battery_mv_i) > rise_th) dep_q <= 1'b0;
    end

    // Power path switches and boost run
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ac_sw_q <= 1'b0;
            bat_sw_q <= 1'b1;
            boost_q <= 1'b0;
        end else begin
            ac_sw_q <= good_q & ~learn_active;
            bat_sw_q <= ~good_q | learn_active;
            boost_q <= opt_q.low[BOOST_EN_BIT] & boost_req_s & good_q
                       & ~dep_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Charge watchdog
    logic [17:0] wdt_cnt_q, wdt_lim;
    logic wdt_en, kick, wdt_off_wr, expire, susp_q, chg_en_q;

    assign wdt_en = (opt_q.wdt_sel != WDT_OFF);
    assign kick = wr_stb_q & (cmd_q == CMD_CHG_VOLT | cmd_q == CMD_CHG_CUR);
    assign wdt_off_wr = wr_stb_q & (cmd_q == CMD_OPTION)
                        & (wr_word.wdt_sel == WDT_OFF);
    // Boost forces the longest period
    assign wdt_lim = boost_q ? WDT_175_MS :
                     (opt_q.wdt_sel == WDT_SEL_44) ? WDT_44_MS :
                     (opt_q.wdt_sel == WDT_SEL_88) ? WDT_88_MS : WDT_175_MS;
    assign expire = wdt_en & tick & ~susp_q
                    & (wdt_cnt_q + 18'h1 >= wdt_lim);

    // Period counter restarts on every voltage or current write
    always_ff @(posedge clk_i) begin
        if (!rstn_i || kick || !wdt_en || susp_q) wdt_cnt_q <= 18'h0;
        else if (tick) wdt_cnt_q <= wdt_cnt_q + 18'h1;
    end

    // Expiry wins over a coincident resume so no timeout is lost
    always_ff @(posedge clk_i) begin
        if (!rstn_i) susp_q <= 1'b0;
        else if (expire) susp_q <= 1'b1;
        else if (kick || wdt_off_wr) susp_q <= 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) chg_en_q <= 1'b0;
        else chg_en_q <= good_q & ~susp_q & ~opt_q.low[INHIBIT_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign adapter_good_indication_o = good_q;
    assign adapter_switch_transistor_o = ac_sw_q;
    assign battery_switch_transistor_o = bat_sw_q;
    assign charge_enable_o = chg_en_q;
    assign boost_run_o = boost_q;
    assign freq_adjust_en_o = opt_q.freq_en;
    assign freq_raise_o = opt_q.freq_up;
    assign high_side_fault_threshold_o = opt_q.hs_fault_en;
    assign depletion_o = dep_q;
    assign wdt_suspended_o = susp_q;

endmodule : cou_charger_option
`default_nettype wire

// File: bench/cou_option_properties.sv
// Pin-level checks for the charger option block.
// Assumes one clock domain; bound into every instance of the block.
`default_nettype none
module cou_option_props #(
    parameter int TICK_CYCLES = 200000 // Cycles per 1 ms tick
) (
    input wire logic clk_i,                       // Block clock
    input wire logic rstn_i,                      // Sync reset, low
    input wire logic smb_scl_i,                   // Bus clock pin
    input wire logic smb_sda_o,                   // Data out value
    input wire logic smb_sda_oe_o,                // Data pull enable
    input wire logic vcc_above_uvlo_i,            // Supply good
    input wire logic adapter_detect_input_i,      // Detect high
    input wire logic adapter_present_i,           // Adapter seen
    input wire logic adapter_good_indication_o,   // Deglitched good
    input wire logic charge_enable_o,             // Charging on
    input wire logic boost_run_o,                 // Boost running
    input wire logic freq_adjust_en_o,            // Shift enable
    input wire logic freq_raise_o,                // Shift up
    input wire logic high_side_fault_threshold_o, // Short detect
    input wire logic depletion_o,                 // Depleted
    input wire logic wdt_suspended_o              // Suspended
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DGL_MIN = 149 * TICK_CYCLES;
    localparam int DGL_MAX = 1310 * TICK_CYCLES;
    // Wide, so the full-rate tick does not overflow
    localparam longint WDT_MIN = longint'(43999) * TICK_CYCLES;
    logic [31:0] pres_q;
    logic [47:0] up_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////
    // Run length of adapter present; one tick of slack below for divider phase, ten ticks above
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !adapter_present_i) pres_q <= '0;
        else if (pres_q != '1) pres_q <= pres_q + 32'h1;
    end
    // Cycles since reset release
    always_ff @(posedge clk_i) begin
        if (!rstn_i) up_q <= '0;
        else if (up_q != '1) up_q <= up_q + 48'h1;
    end
    chk_sda_value_low: assert property (smb_sda_o == 1'b0)
        else $error("data out value not low");
    chk_ack_scl_low: assert property (
        $changed(smb_sda_oe_o) |-> !smb_scl_i)
        else $error("data pull changed with clock high");
    chk_opt_gated: assert property (
        ($changed(freq_raise_o) || $changed(freq_adjust_en_o) ||
        $changed(high_side_fault_threshold_o)) |->
        vcc_above_uvlo_i && adapter_detect_input_i)
        else $error("option changed while bus disabled");
    chk_dgl_min: assert property (
        $rose(adapter_good_indication_o) |-> pres_q >= DGL_MIN)
        else $error("adapter good too early");
    chk_dgl_max: assert property (
        pres_q == DGL_MAX |-> adapter_good_indication_o)
        else $error("adapter good too late");
    chk_dgl_drop: assert property (
        !adapter_present_i [*4] |-> !adapter_good_indication_o)
        else $error("adapter good held after removal");
    chk_boost_stop: assert property (
        depletion_o || !adapter_good_indication_o |=> !boost_run_o)
        else $error("boost kept running");
    chk_wdt_charge: assert property (
        wdt_suspended_o && $past(wdt_suspended_o) |-> !charge_enable_o)
        else $error("charging while suspended");
    chk_wdt_early: assert property (
        $rose(wdt_suspended_o) |-> up_q >= WDT_MIN)
        else $error("watchdog expired too early");
    cov_good: cover property ($rose(adapter_good_indication_o));
    cov_susp: cover property ($rose(wdt_suspended_o));
    cov_dep: cover property ($rose(depletion_o) ##[1:4] !boost_run_o);
endmodule : cou_option_props
bind cou_charger_option cou_option_props #(.TICK_CYCLES(TICK_CYCLES)) u_p (
    .clk_i(clk_i), .rstn_i(rstn_i), .smb_scl_i(smb_scl_i),
    .smb_sda_o(smb_sda_o), .smb_sda_oe_o(smb_sda_oe_o),
    .vcc_above_uvlo_i(vcc_above_uvlo_i),
    .adapter_detect_input_i(adapter_detect_input_i),
    .adapter_present_i(adapter_present_i),
    .adapter_good_indication_o(adapter_good_indication_o),
    .charge_enable_o(charge_enable_o), .boost_run_o(boost_run_o),
    .freq_adjust_en_o(freq_adjust_en_o), .freq_raise_o(freq_raise_o),
    .high_side_fault_threshold_o(high_side_fault_threshold_o),
    .depletion_o(depletion_o), .wdt_suspended_o(wdt_suspended_o));
`default_nettype wire

// File: bench/cou_smb_host.sv
// Host controller model: word write and word read transfers.
// Assumes the bench resolves the data wire with a pull-up.
`default_nettype none
module cou_smb_host import cou_pkg::*; (
    input wire logic clk_i, // Bench clock
    input wire logic sda_i, // Resolved data wire
    output logic scl_o,     // Clock pin
    output logic sda_o      // Data drive, 1 releases
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {scl_o, sda_o} = 2'b11;
    ////////////////////////////////////////
    // Five clocks a phase, above the slave's four-cycle minimum
    task automatic ph(input logic c, input logic d);
        scl_o <= c;
        sda_o <= d;
        repeat (5) @(posedge clk_i);
    endtask : ph
    // Data set while low, held across the high phase and after it
    task automatic bit_io(input logic b, output logic r);
        ph(1'b0, b);
        ph(1'b1, b);
        r = sda_i;
        ph(1'b0, b);
    endtask : bit_io
    task automatic byte_io(input logic [7:0] b, output logic [7:0] r,
                           input logic m, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
        bit_io(m, a);
    endtask : byte_io
    task automatic st();
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask : st
    task automatic sp();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask : sp
    // Address, command, low byte, high byte; ok when all acked
    task automatic wr(input logic [7:0] c, input logic [15:0] d,
                      output logic ok);
        logic [7:0] r;
        logic [3:0] a;
        st();
        byte_io({SMB_ADDR, 1'b0}, r, 1'b1, a[0]);
        byte_io(c, r, 1'b1, a[1]);
        byte_io(d[7:0], r, 1'b1, a[2]);
        byte_io(d[15:8], r, 1'b1, a[3]);
        sp();
        ok = (a == 4'h0);
    endtask : wr
    // Repeated start, then low byte acked and high byte refused
    task automatic rd(input logic [7:0] c, output logic [15:0] d,
                      output logic ok);
        logic [7:0] r;
        logic [2:0] a;
        logic x;
        st();
        byte_io({SMB_ADDR, 1'b0}, r, 1'b1, a[0]);
        byte_io(c, r, 1'b1, a[1]);
        ph(1'b0, 1'b1);
        st();
        byte_io({SMB_ADDR, 1'b1}, r, 1'b1, a[2]);
        byte_io(8'hFF, d[7:0], 1'b0, x);
        byte_io(8'hFF, d[15:8], 1'b1, x);
        sp();
        ok = (a == 3'h0);
    endtask : rd
endmodule : cou_smb_host
`default_nettype wire

// File: bench/tb_cou_charger_option.sv
// Bench for the charger option block with a host model on the bus.
// Assumes the package, host model and checker are compiled first.
`default_nettype none
module tb_cou_charger_option import cou_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, vcc = 1'b1, det = 1'b1;
    logic pres = 1'b0, breq = 1'b0, scl, sda_m, sda, oe, sda_d, ok;
    logic good, asw, bsw, chg, bst, fen, fup, hs, dep, sus;
    logic [15:0] vbat = 16'h2710, rdv;
    logic [31:0] seed = 32'hA5B6;
    int errors = 0, total_checks = 0, vset = 0, opt = 'hF902;
    assign sda = sda_m & ~oe;
    cou_charger_option #(.TICK_CYCLES(1)) DUT (
        .clk_i(clk), .rstn_i(rstn), .smb_scl_i(scl), .smb_sda_i(sda),
        .smb_sda_o(sda_d), .smb_sda_oe_o(oe), .vcc_above_uvlo_i(vcc),
        .adapter_detect_input_i(det), .adapter_present_i(pres),
        .boost_request_i(breq), .battery_mv_i(vbat),
        .adapter_good_indication_o(good), .adapter_switch_transistor_o(asw),
        .battery_switch_transistor_o(bsw), .charge_enable_o(chg),
        .boost_run_o(bst), .freq_adjust_en_o(fen), .freq_raise_o(fup),
        .high_side_fault_threshold_o(hs), .depletion_o(dep),
        .wdt_suspended_o(sus));
    cou_smb_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    ////////////////////////////////////////
    initial forever #2.5 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Reference falling threshold for select 11
    function automatic logic [15:0] fall();
        return 16'(vset * 7097 / 10000);
    endfunction : fall
    // Writes update the reference only when the bus is enabled
    task automatic wo(input logic [15:0] v);
        host.wr(CMD_OPTION, v, ok);
        if (vcc && det) opt = v;
    endtask : wo
    task automatic wv(input logic [15:0] v);
        host.wr(CMD_CHG_VOLT, v, ok);
        vset = v;
    endtask : wv
    // Read-only bits show live adapter and boost state
    task automatic ro(input logic p, input logic b);
        host.rd(CMD_OPTION, rdv, ok);
        chk(rdv, 16'(opt & 'hFFEB) | {11'h0, p, 1'b0, b, 2'b0});
    endtask : ro
    task automatic wait_sus(input int n);
        for (int i = 0; i < n && sus !== 1'b1; i++) @(posedge clk);
        cyc(2);
    endtask : wait_sus
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    // Hang guard, nearly one more period beyond the two watchdog periods
    initial begin
        cyc(130000);
        errors++;
        print_verdict();
    end
    initial begin
        cyc(4);
        rstn <= 1'b1;
        cyc(4);
        chk({hs, fen, fup}, 3'b100);
        chk({good, bsw, sus, dep}, 4'b0100);
        ro(1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            {vcc, det} <= k ? 2'b10 : 2'b01;
            wo(16'h0702);
            chk(ok, 1'b0);
        end
        {vcc, det} <= 2'b11;
        ro(1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wo({seed[15:8], 8'h02});
            chk({fup, fen, hs}, seed[10:8]);
            ro(1'b0, 1'b0);
        end
        $display("test reset and options done");
        wo(16'hB902);
        pres <= 1'b1;
        cyc(145);
        chk(good, 1'b0);
        cyc(15);
        chk({good, chg}, 2'b11);
        wv(16'd10000);
        vbat <= 16'd9000;
        breq <= 1'b1;
        wo(16'hB94A);
        chk({asw, bsw, bst}, 3'b011);
        vbat <= fall() - 16'd1;
        cyc(4);
        chk({dep, bst, asw, bsw}, 4'b1010);
        opt = 'hB90A;
        ro(1'b1, 1'b0);
        vbat <= fall() + 16'd340;
        cyc(4);
        chk(dep, 1'b1);
        vbat <= fall() + 16'd341;
        cyc(4);
        chk({dep, bst}, 2'b01);
        ro(1'b1, 1'b1);
        breq <= 1'b0;
        // Zero voltage setting must drop a set depletion flag
        vbat <= 16'd1;
        cyc(4);
        chk(dep, 1'b1);
        wv(16'd0);
        chk(dep, 1'b0);
        $display("test depletion done");
        // Adapter switch has opened once, so bit 15 now counts
        pres <= 1'b0;
        cyc(10);
        chk(good, 1'b0);
        pres <= 1'b1;
        cyc(1290);
        chk(good, 1'b0);
        cyc(20);
        chk(good, 1'b1);
        $display("test deglitch done");
        wv(16'd10000);
        cyc(43000);
        chk({chg, sus}, 2'b10);
        wait_sus(2000);
        chk({chg, sus}, 2'b01);
        host.wr(CMD_CHG_CUR, 16'h0100, ok);
        chk({chg, sus}, 2'b10);
        wait_sus(46000);
        chk({chg, sus}, 2'b01);
        wo(16'h980A);
        chk({chg, sus}, 2'b10);
        $display("test watchdog done");
        print_verdict();
    end
endmodule : tb_cou_charger_option
`default_nettype wire
